// File: tes_pkg.sv
package tes_pkg;

  // Big-endian bit numbers 32..63 map onto little-endian word bits 31..0.
  localparam int TES_WIDTH = 32;
  // Field positions in the little-endian view of the status word.
  localparam int TES_NEXT_WD_BIT = 31;
  localparam int TES_WD_STATUS_BIT = 30;
  localparam int TES_WD_RST_HI = 29;
  localparam int TES_WD_RST_LO = 28;
  localparam int TES_DEC_STATUS_BIT = 27;
  localparam int TES_FI_STATUS_BIT = 26;
  // Value of the status word after reset.
  localparam logic [31:0] TES_RESET_VALUE = 32'h0000_0000;
  // Codes of the reset control and reset status fields.
  localparam logic [1:0] TES_RSTCTL_NONE = 2'h0;
  localparam logic [1:0] TES_RSTCTL_CHECKSTOP = 2'h1;
  localparam logic [1:0] TES_RSTCTL_RESET = 2'h2;
  // Widths of the time base and of the time-base bit selector fed to the edge detectors.
  localparam int TES_TB_WIDTH = 64;
  localparam int TES_SEL_WIDTH = 6;

endpackage

// File: tes_rise_detect.sv
`timescale 1ns/10ps

// Picks one time-base bit and pulses on its 0-to-1 change.
module tes_rise_detect
  import tes_pkg::*;
#(
  parameter int TB_WIDTH = TES_TB_WIDTH,
  parameter int SEL_WIDTH = TES_SEL_WIDTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [TB_WIDTH-1:0] time_base_i,
  input wire logic [SEL_WIDTH-1:0] select_i,
  output logic rise_o
);

  // Selected bit; select 0 is the most significant bit of the time base.
  logic picked;
  // Previous value of the selected bit.
  logic prev_reg;

  assign picked = time_base_i[TB_WIDTH-1-int'(select_i)];

  // Remember the bit so a change of selection alone can still produce an edge, as in hardware.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_reg <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      prev_reg <= picked;
      rise_o <= picked & ~prev_reg;
    end
  end

endmodule

// File: tes_status.sv
`timescale 1ns/10ps

// Summary of operation
// - Write is a clear mask, never sets.
// - Time-out with status clear, enable set: log.
// - Time-out with enable clear: set enable only.
// - Watchdog request needs status, enable, critical enable.
// - Two-bit reset status field records second time-out.
// - Decrementer event sets flag; gated request.
// - Fixed-interval event sets flag; gated request.
// - Read returns whole word; no direct writes.
// - Watchdog time-out on selected bit rising.
// - Fixed-interval event on selected bit rising.
// - Reset control selects none, checkstop, reset.
module tes_status
  import tes_pkg::*;
#(
  parameter int TB_WIDTH = TES_TB_WIDTH,
  parameter int SEL_WIDTH = TES_SEL_WIDTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [TB_WIDTH-1:0] time_base_i,
  input wire logic [SEL_WIDTH-1:0] watchdog_select_i,
  input wire logic [SEL_WIDTH-1:0] fixed_interval_select_i,
  input wire logic decrementer_event_i,
  input wire logic [1:0] watchdog_reset_control_i,
  input wire logic watchdog_irq_enable_i,
  input wire logic decrementer_irq_enable_i,
  input wire logic fixed_interval_irq_enable_i,
  input wire logic critical_irq_enable_i,
  input wire logic external_irq_enable_i,
  input wire logic status_read_i,
  input wire logic status_clear_i,
  input wire logic [TES_WIDTH-1:0] status_clear_mask_i,
  output logic [TES_WIDTH-1:0] status_read_data_o,
  output logic watchdog_irq_o,
  output logic decrementer_irq_o,
  output logic fixed_interval_irq_o,
  output logic checkstop_o,
  output logic reset_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Event detection.
  ////////////////////////////////////////////////////////////////////////////

  // One-cycle pulse on a watchdog time-out.
  logic watchdog_timeout;
  // One-cycle pulse on a fixed-interval event.
  logic fixed_interval_event;

  // The watchdog time-out comes from the selected time-base bit rising.
  tes_rise_detect #(
    .TB_WIDTH(TB_WIDTH),
    .SEL_WIDTH(SEL_WIDTH)
  ) u_watchdog_edge (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .time_base_i(time_base_i),
    .select_i(watchdog_select_i),
    .rise_o(watchdog_timeout)
  );

  // The fixed-interval event comes from its own selected bit rising.
  tes_rise_detect #(
    .TB_WIDTH(TB_WIDTH),
    .SEL_WIDTH(SEL_WIDTH)
  ) u_fixed_edge (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .time_base_i(time_base_i),
    .select_i(fixed_interval_select_i),
    .rise_o(fixed_interval_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status flags.
  ////////////////////////////////////////////////////////////////////////////

  // Status flags, each held in its own register.
  logic next_watchdog_enable_reg;
  logic watchdog_irq_status_reg;
  logic [1:0] watchdog_reset_status_reg;
  logic decrementer_irq_status_reg;
  logic fixed_interval_irq_status_reg;
  // Clear strobes per field, decoded from the mask.
  logic clr_next_wd;
  logic clr_wd_status;
  logic [1:0] clr_wd_rst;
  logic clr_dec_status;
  logic clr_fi_status;
  // Classification of the current time-out.
  logic wd_first;
  logic wd_second;

  // Only the clear-mask form reaches the flags; bits below the fields are ignored.
  assign clr_next_wd = status_clear_i & status_clear_mask_i[TES_NEXT_WD_BIT];
  assign clr_wd_status = status_clear_i & status_clear_mask_i[TES_WD_STATUS_BIT];
  assign clr_wd_rst = {2{status_clear_i}} & status_clear_mask_i[TES_WD_RST_HI:TES_WD_RST_LO];
  assign clr_dec_status = status_clear_i & status_clear_mask_i[TES_DEC_STATUS_BIT];
  assign clr_fi_status = status_clear_i & status_clear_mask_i[TES_FI_STATUS_BIT];

  // First time-out logs the exception; second finds both flags already set.
  assign wd_first = watchdog_timeout & next_watchdog_enable_reg & ~watchdog_irq_status_reg;
  assign wd_second = watchdog_timeout & next_watchdog_enable_reg & watchdog_irq_status_reg;

  // Next-watchdog enable: set on a time-out that finds it clear; set wins over clear.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      next_watchdog_enable_reg <= TES_RESET_VALUE[TES_NEXT_WD_BIT];
    end else if (watchdog_timeout && !next_watchdog_enable_reg) begin
      next_watchdog_enable_reg <= 1'b1;
    end else if (clr_next_wd) begin
      next_watchdog_enable_reg <= 1'b0;
    end
  end

  // Watchdog interrupt status: a set in the clear cycle is kept.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      watchdog_irq_status_reg <= TES_RESET_VALUE[TES_WD_STATUS_BIT];
    end else if (wd_first) begin
      watchdog_irq_status_reg <= 1'b1;
    end else if (clr_wd_status) begin
      watchdog_irq_status_reg <= 1'b0;
    end
  end

  // Reset status takes the control code on a second time-out.
  // Each bit clears alone under the mask, but a fresh copy beats a clear.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      watchdog_reset_status_reg <= TES_RESET_VALUE[TES_WD_RST_HI:TES_WD_RST_LO];
    end else if (wd_second) begin
      watchdog_reset_status_reg <= watchdog_reset_control_i;
    end else begin
      watchdog_reset_status_reg <= watchdog_reset_status_reg & ~clr_wd_rst;
    end
  end

  // Decrementer status flag.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      decrementer_irq_status_reg <= TES_RESET_VALUE[TES_DEC_STATUS_BIT];
    end else if (decrementer_event_i) begin
      decrementer_irq_status_reg <= 1'b1;
    end else if (clr_dec_status) begin
      decrementer_irq_status_reg <= 1'b0;
    end
  end

  // Fixed-interval status flag.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fixed_interval_irq_status_reg <= TES_RESET_VALUE[TES_FI_STATUS_BIT];
    end else if (fixed_interval_event) begin
      fixed_interval_irq_status_reg <= 1'b1;
    end else if (clr_fi_status) begin
      fixed_interval_irq_status_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, requests and second time-out actions.
  ////////////////////////////////////////////////////////////////////////////

  // Whole status word; unused positions read as zero.
  logic [TES_WIDTH-1:0] status_word;

  always_comb begin
    status_word = TES_RESET_VALUE;
    status_word[TES_NEXT_WD_BIT] = next_watchdog_enable_reg;
    status_word[TES_WD_STATUS_BIT] = watchdog_irq_status_reg;
    status_word[TES_WD_RST_HI:TES_WD_RST_LO] = watchdog_reset_status_reg;
    status_word[TES_DEC_STATUS_BIT] = decrementer_irq_status_reg;
    status_word[TES_FI_STATUS_BIT] = fixed_interval_irq_status_reg;
  end

  // Read data is captured on the edge that samples the read strobe and held until the next read.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_read_data_o <= TES_RESET_VALUE;
    end else if (status_read_i) begin
      status_read_data_o <= status_word;
    end
  end

  // Interrupt requests follow the flags and the enables with one cycle of lag.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      watchdog_irq_o <= 1'b0;
      decrementer_irq_o <= 1'b0;
      fixed_interval_irq_o <= 1'b0;
    end else begin
      watchdog_irq_o <= watchdog_irq_status_reg & watchdog_irq_enable_i
                        & critical_irq_enable_i;
      decrementer_irq_o <= decrementer_irq_status_reg & decrementer_irq_enable_i
                           & external_irq_enable_i;
      fixed_interval_irq_o <= fixed_interval_irq_status_reg & fixed_interval_irq_enable_i
                              & external_irq_enable_i;
    end
  end

  // Second time-out actions are sticky levels; only a reset ends them,
  // since the checkstop or reset logic outside is expected to act on them.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      checkstop_o <= 1'b0;
      reset_out_o <= 1'b0;
    end else if (wd_second) begin
      case (watchdog_reset_control_i)
        TES_RSTCTL_CHECKSTOP: checkstop_o <= 1'b1;
        TES_RSTCTL_RESET: reset_out_o <= 1'b1;
        default: begin
          // No action for code zero, nor for the reserved code.
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////////

  sequence s_second_timeout;
    watchdog_timeout && next_watchdog_enable_reg && watchdog_irq_status_reg;
  endsequence

  a_clear_never_sets: assert property (@(posedge clk_i) disable iff (srst_i)
    (status_clear_i && !watchdog_timeout && !decrementer_event_i && !fixed_interval_event)
    |=> (status_word & ~$past(status_word)) == '0)
    else $error("A clear write set a status bit.");

  a_first_timeout_logs: assert property (@(posedge clk_i) disable iff (srst_i)
    (watchdog_timeout && next_watchdog_enable_reg && !watchdog_irq_status_reg)
    |=> watchdog_irq_status_reg)
    else $error("First time-out did not log the watchdog status.");

  a_enable_only: assert property (@(posedge clk_i) disable iff (srst_i)
    (watchdog_timeout && !next_watchdog_enable_reg)
    |=> next_watchdog_enable_reg
        && (watchdog_irq_status_reg
            == ($past(watchdog_irq_status_reg) && !$past(clr_wd_status)))
        && (watchdog_reset_status_reg
            == ($past(watchdog_reset_status_reg) & ~$past(clr_wd_rst))))
    else $error("Time-out with enable clear did more than set enable.");

  a_watchdog_request: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 watchdog_irq_o == $past(watchdog_irq_status_reg && watchdog_irq_enable_i
                                && critical_irq_enable_i))
    else $error("Watchdog request does not follow its gate.");

  a_reset_status_copy: assert property (@(posedge clk_i) disable iff (srst_i)
    s_second_timeout |=> watchdog_reset_status_reg == $past(watchdog_reset_control_i))
    else $error("Reset status did not take the control code.");

  a_second_action: assert property (@(posedge clk_i) disable iff (srst_i)
    (s_second_timeout ##0 watchdog_reset_control_i == TES_RSTCTL_RESET)
    |=> reset_out_o ##1 reset_out_o)
    else $error("Reset output not asserted on second time-out.");

  a_decrementer_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    decrementer_event_i |=> decrementer_irq_status_reg
    ##1 (decrementer_irq_o == ($past(decrementer_irq_enable_i) && $past(external_irq_enable_i))))
    else $error("Decrementer event not logged or request wrong.");

  a_fixed_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    fixed_interval_event |=> fixed_interval_irq_status_reg)
    else $error("Fixed-interval event not logged.");

  a_read_word: assert property (@(posedge clk_i) disable iff (srst_i)
    status_read_i |=> status_read_data_o == $past(status_word)
    && status_read_data_o[TES_FI_STATUS_BIT-1:0] == '0)
    else $error("Read data does not match the status word.");

  a_fixed_rise: assert property (@(posedge clk_i) disable iff (srst_i)
    fixed_interval_event |-> $past(time_base_i[TB_WIDTH-1-int'(fixed_interval_select_i)])
    ##1 !fixed_interval_event)
    else $error("Fixed-interval event without a rising bit, or longer than one cycle.");

endmodule

// File: timer_event_status_tb_top.sv
`timescale 1ns/10ps

// Self-checking bench for the timer status word: events, gated requests, clear-mask writes.
module timer_event_status_tb_top
  import tes_pkg::*;
;

  // Time-base bits picked by the two selectors; select s picks bit 63-s.
  localparam int WD_BIT = 58;
  localparam int FI_BIT = 53;
  localparam int LIMIT = 2000;

  ////////////////////////////////////////////////////////////////////////////////
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [63:0] time_base_i = '0;
  // Selectors are driven nets so a test can move the watched bit.
  logic [5:0] watchdog_select_i = 6'h05;
  logic [5:0] fixed_interval_select_i = 6'h0A;
  logic decrementer_event_i = 1'b0;
  logic [1:0] watchdog_reset_control_i = 2'h0;
  logic watchdog_irq_enable_i = 1'b1;
  logic decrementer_irq_enable_i = 1'b1;
  logic fixed_interval_irq_enable_i = 1'b1;
  logic critical_irq_enable_i = 1'b1;
  logic external_irq_enable_i = 1'b1;
  logic status_read_i = 1'b0;
  logic status_clear_i = 1'b0;
  logic [31:0] status_clear_mask_i = '0;
  logic [31:0] status_read_data_o;
  logic watchdog_irq_o;
  logic decrementer_irq_o;
  logic fixed_interval_irq_o;
  logic checkstop_o;
  logic reset_out_o;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  // The clock toggles every half period of 50 ns.
  always #50 clk_i = ~clk_i;

  tes_status #(.TB_WIDTH(TES_TB_WIDTH), .SEL_WIDTH(TES_SEL_WIDTH)) dut_u (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .time_base_i(time_base_i),
    .watchdog_select_i(watchdog_select_i),
    .fixed_interval_select_i(fixed_interval_select_i),
    .decrementer_event_i(decrementer_event_i),
    .watchdog_reset_control_i(watchdog_reset_control_i),
    .watchdog_irq_enable_i(watchdog_irq_enable_i),
    .decrementer_irq_enable_i(decrementer_irq_enable_i),
    .fixed_interval_irq_enable_i(fixed_interval_irq_enable_i),
    .critical_irq_enable_i(critical_irq_enable_i),
    .external_irq_enable_i(external_irq_enable_i),
    .status_read_i(status_read_i),
    .status_clear_i(status_clear_i),
    .status_clear_mask_i(status_clear_mask_i),
    .status_read_data_o(status_read_data_o),
    .watchdog_irq_o(watchdog_irq_o),
    .decrementer_irq_o(decrementer_irq_o),
    .fixed_interval_irq_o(fixed_interval_irq_o),
    .checkstop_o(checkstop_o),
    .reset_out_o(reset_out_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang would leave the run waiting forever, so cut it at a fixed cycle ceiling.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  // Compares a whole status word.
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares a single request or action output.
  task automatic chk_bit(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One access cycle; read data is settled at the falling edge after the strobe edge.
  task automatic access(input logic rd, input logic clr, input logic [31:0] mask);
    @(negedge clk_i);
    status_read_i = rd;
    status_clear_i = clr;
    status_clear_mask_i = mask;
    @(negedge clk_i);
    status_read_i = 1'b0;
    status_clear_i = 1'b0;
  endtask

  task automatic read_word(output logic [31:0] word);
    access(1'b1, 1'b0, 32'h0000_0000);
    word = status_read_data_o;
  endtask

  // Raises the picked bit long enough for the two-stage detector, then drops it.
  task automatic pulse_bit(input int idx);
    @(negedge clk_i);
    time_base_i[idx] = 1'b1;
    idle(4);
    time_base_i[idx] = 1'b0;
    idle(1);
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    srst_i = 1'b1;
    idle(5);
    srst_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] w;
  // Every control code, the reserved one too; the reset code runs last.
  logic [1:0] codes [4] = '{2'h1, 2'h3, 2'h0, 2'h2};

  initial begin
    do_reset();
    read_word(w);
    chk_word(TES_RESET_VALUE, w);
    // Each action code goes through first, second and third time-out.
    foreach (codes[i]) begin
      do_reset();
      watchdog_reset_control_i = codes[i];
      pulse_bit(WD_BIT);
      read_word(w);
      chk_word(32'h8000_0000, w);
      chk_bit(1'b0, watchdog_irq_o);
      pulse_bit(WD_BIT);
      read_word(w);
      chk_word(32'hC000_0000, w);
      chk_bit(1'b1, watchdog_irq_o);
      critical_irq_enable_i = 1'b0;
      idle(2);
      chk_bit(1'b0, watchdog_irq_o);
      critical_irq_enable_i = 1'b1;
      pulse_bit(WD_BIT);
      read_word(w);
      chk_word({2'h3, codes[i], 28'h0}, w);
      chk_bit(codes[i] == TES_RSTCTL_CHECKSTOP, checkstop_o);
      chk_bit(codes[i] == TES_RSTCTL_RESET, reset_out_o);
      // The handler clears only the interrupt flag; the enable and reset status stay set.
      access(1'b0, 1'b1, 32'h4000_0000);
      read_word(w);
      chk_word({2'h2, codes[i], 28'h0}, w);
      idle(1);
      chk_bit(1'b0, watchdog_irq_o);
    end
    do_reset();
    chk_bit(1'b0, reset_out_o);
    // Decrementer event with its request gated by the machine-state enable.
    @(negedge clk_i);
    decrementer_event_i = 1'b1;
    @(negedge clk_i);
    decrementer_event_i = 1'b0;
    idle(2);
    read_word(w);
    chk_word(32'h0800_0000, w);
    chk_bit(1'b1, decrementer_irq_o);
    external_irq_enable_i = 1'b0;
    idle(2);
    chk_bit(1'b0, decrementer_irq_o);
    external_irq_enable_i = 1'b1;
    pulse_bit(FI_BIT);
    read_word(w);
    chk_word(32'h0C00_0000, w);
    chk_bit(1'b1, fixed_interval_irq_o);
    fixed_interval_irq_enable_i = 1'b0;
    idle(2);
    chk_bit(1'b0, fixed_interval_irq_o);
    // A zero mask changes nothing; a write never sets a flag.
    access(1'b0, 1'b1, 32'h0000_0000);
    read_word(w);
    chk_word(32'h0C00_0000, w);
    // Read and clear together: the read sees the word before the clear.
    access(1'b1, 1'b1, 32'h0800_0000);
    chk_word(32'h0C00_0000, status_read_data_o);
    read_word(w);
    chk_word(32'h0400_0000, w);
    // An event in the cycle of its own clear wins, so the flag stays set.
    decrementer_event_i = 1'b1;
    access(1'b0, 1'b1, 32'h0800_0000);
    decrementer_event_i = 1'b0;
    read_word(w);
    chk_word(32'h0C00_0000, w);
    complete_run();
  end

endmodule
